/* bench/sdm_host_model.sv */
// Host side of the register port of the diagnostic monitor.
// Assumes one clock; the bench calls wr and rd by hierarchical name.
`timescale 1ns/1ps
module sdm_host_model (
   input  wire logic        core_clk_in,
   input  wire logic [31:0] reg_rdata_in,
   output logic      [7:0]  reg_addr_out,
   output logic      [31:0] reg_wdata_out,
   output logic             reg_wr_out,
   output logic             reg_rd_out
);
   ////////////////////////////////////////////////////////////////////////////
   // Idle bus at time zero
   initial
   begin
      reg_addr_out  = 8'hff;
      reg_wdata_out = 32'h0000_0000;
      reg_wr_out    = 1'b0;
      reg_rd_out    = 1'b0;
   end

   // One-cycle write; released lines show the inverse so stale data never looks valid
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk_in);
      reg_addr_out  <= a;
      reg_wdata_out <= d;
      reg_wr_out    <= 1'b1;
      @(posedge core_clk_in);
      reg_wr_out    <= 1'b0;
      reg_addr_out  <= ~a;
      reg_wdata_out <= ~d;
   endtask : wr

   // One-cycle read; data stands only in the following cycle, taken mid-cycle
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge core_clk_in);
      reg_addr_out <= a;
      reg_rd_out   <= 1'b1;
      @(posedge core_clk_in);
      reg_rd_out   <= 1'b0;
      reg_addr_out <= ~a;
      @(negedge core_clk_in);
      d = reg_rdata_in;
   endtask : rd
endmodule : sdm_host_model

/* bench/sensor_diagnostic_monitor_tb.sv */
// Self-checking bench of the diagnostic monitor.
// Assumes sdm_defines.svh on the include path and a short frequency gate.
`timescale 1ns/1ps
`include "sdm_defines.svh"
module sensor_diagnostic_monitor_tb;
   import sdm_pkg::*;
   localparam sdm_word_t GATE = 16'h0010;
   logic        core_clk_in;
   logic        reset_in;
   logic        core_en_in;
   logic [7:0]  addr;
   logic [31:0] wdata;
   logic        wr;
   logic        rd;
   logic [31:0] rdata;
   logic [5:0]  pins;
   logic        tx_osc;
   logic        osc_run;
   logic [1:0]  osc_cnt;
   logic        irq_n;
   int          mismatches;
   int          n_tests;

   ////////////////////////////////////////////////////////////////////////////
   sdm_monitor #(.GATE_CYC(GATE)) DUT (
      .core_clk_in(core_clk_in), .reset_in(reset_in), .core_en_in(core_en_in),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_rdata_out(rdata), .mech_damage_in(pins[`SDM_P_MECH]),
      .out_mean_fault_in(pins[`SDM_P_OMEAN]), .out_overload_in(pins[`SDM_P_OOVL]),
      .coil_short_in(pins[`SDM_P_SHORT]), .receive_coil_first_fault_in(pins[`SDM_P_COIL1]),
      .receive_coil_second_fault_in(pins[`SDM_P_COIL2]), .tx_osc_in(tx_osc),
      .select_or_interrupt_pin_n_out(irq_n));
   sdm_host_model HOST (
      .core_clk_in(core_clk_in), .reg_rdata_in(rdata), .reg_addr_out(addr),
      .reg_wdata_out(wdata), .reg_wr_out(wr), .reg_rd_out(rd));

   // Clock, 100 ns period
   initial
   begin
      core_clk_in = 1'b0;
      forever #50 core_clk_in = ~core_clk_in;
   end

   // Oscillator of period 8 cycles, still while not running
   always @(posedge core_clk_in)
   begin
      osc_cnt <= osc_cnt + 2'h1;
      if (osc_run && osc_cnt == 2'h3)
         tx_osc <= ~tx_osc;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      if (mismatches == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : report_and_stop

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      HOST.rd(a, d);
      chk(d, exp);
   endtask : rdchk

   task automatic flagchk(input logic [7:0] a, input int b, input logic v);
      logic [31:0] d;
      HOST.rd(a, d);
      chk(32'(d[b]), 32'(v));
   endtask : flagchk

   task automatic pinchk(input logic v);
      @(negedge core_clk_in);
      chk(32'(irq_n), 32'(v));
   endtask : pinchk

   // Polls a bit under a bound; running out ends the run
   task automatic wait_bit(input logic [7:0] a, input int b);
      logic [31:0] d;
      d = 32'h0000_0000;
      for (int i = 0; i < 12 && d[b] !== 1'b1; i++)
         HOST.rd(a, d);
      chk(32'(d[b]), 32'h0000_0001);
      if (d[b] !== 1'b1)
         report_and_stop();
   endtask : wait_bit

   ////////////////////////////////////////////////////////////////////////////
   // Reset values, unmapped read, startup coil short sample
   task automatic t_reset();
      pinchk(1'b1);
      chk(rdata, 32'h0000_0000);
      rdchk(`SDM_REG_STATUS, 32'h0000_0000);
      rdchk(`SDM_REG_MASK, 32'h0000_0000);
      rdchk(`SDM_REG_WDOG, 32'h0000_0000);
      rdchk(`SDM_REG_LO, 32'h0000_0000);
      rdchk(`SDM_REG_HI, 32'h0000_ffff);
      rdchk(`SDM_REG_FREQ, 32'h0000_0000);
      rdchk(8'h20, 32'h0000_0000);
      rdchk(`SDM_REG_INJ, 32'h0000_0000);
      repeat (4) @(posedge core_clk_in);
      flagchk(`SDM_REG_FLAGS, `SDM_F_SHORT, 1'b1);
      @(posedge core_clk_in);
      pins[`SDM_P_SHORT] <= 1'b0;
      repeat (6) @(posedge core_clk_in);
      flagchk(`SDM_REG_FLAGS, `SDM_F_SHORT, 1'b1);
   endtask : t_reset

   // Temporary flags follow their pins both ways
   task automatic t_temp();
      int p[4] = '{`SDM_P_OMEAN, `SDM_P_OOVL, `SDM_P_COIL1, `SDM_P_COIL2};
      int f[4] = '{`SDM_F_OMEAN, `SDM_F_OOVL, `SDM_F_COIL1, `SDM_F_COIL2};
      for (int i = 0; i < 4; i++)
      begin
         @(posedge core_clk_in);
         pins[p[i]] <= 1'b1;
         repeat (4) @(posedge core_clk_in);
         flagchk(`SDM_REG_FLAGS, f[i], 1'b1);
         @(posedge core_clk_in);
         pins[p[i]] <= 1'b0;
         repeat (4) @(posedge core_clk_in);
         flagchk(`SDM_REG_FLAGS, f[i], 1'b0);
      end
   endtask : t_temp

   // Short damage pulse stays latched
   task automatic t_mech();
      @(posedge core_clk_in);
      pins[`SDM_P_MECH] <= 1'b1;
      repeat (3) @(posedge core_clk_in);
      pins[`SDM_P_MECH] <= 1'b0;
      repeat (6) @(posedge core_clk_in);
      rdchk(`SDM_REG_FLAGS, 32'h0000_0012);
   endtask : t_mech

   // Enable bits gate the pin; a held temporary flag keeps it low
   task automatic t_irq();
      rdchk(`SDM_REG_STATUS, 32'h0000_007e);
      pinchk(1'b1);
      HOST.wr(`SDM_REG_MASK, 32'h0000_0004);
      repeat (2) @(posedge core_clk_in);
      pinchk(1'b0);
      HOST.wr(`SDM_REG_STATUS, 32'h0000_0004);
      repeat (2) @(posedge core_clk_in);
      pinchk(1'b1);
      @(posedge core_clk_in);
      pins[`SDM_P_OMEAN] <= 1'b1;
      repeat (6) @(posedge core_clk_in);
      HOST.wr(`SDM_REG_STATUS, 32'h0000_0004);
      repeat (2) @(posedge core_clk_in);
      pinchk(1'b0);
      @(posedge core_clk_in);
      pins[`SDM_P_OMEAN] <= 1'b0;
      repeat (6) @(posedge core_clk_in);
      HOST.wr(`SDM_REG_STATUS, 32'h0000_03ff);
      repeat (2) @(posedge core_clk_in);
      pinchk(1'b1);
      rdchk(`SDM_REG_STATUS, 32'h0000_0000);
   endtask : t_irq

   // Cyclic watchdog requests, then halted by period zero
   task automatic t_wdog();
      HOST.wr(`SDM_REG_MASK, 32'h0000_0001);
      HOST.wr(`SDM_REG_WDOG, 32'h0000_0008);
      rdchk(`SDM_REG_WDOG, 32'h0000_0008);
      for (int i = 0; i < 3; i++)
      begin
         wait_bit(`SDM_REG_STATUS, `SDM_F_WDOG);
         HOST.wr(`SDM_REG_STATUS, 32'h0000_0001);
      end
      flagchk(`SDM_REG_FLAGS, `SDM_F_WDOG, 1'b1);
      HOST.wr(`SDM_REG_WDOG, 32'h0000_0000);
      HOST.wr(`SDM_REG_STATUS, 32'h0000_0001);
      repeat (30) @(posedge core_clk_in);
      flagchk(`SDM_REG_STATUS, `SDM_F_WDOG, 1'b0);
      pinchk(1'b1);
   endtask : t_wdog

   // Low enable freezes state, so a write in that time is lost
   task automatic t_freeze();
      @(posedge core_clk_in);
      core_en_in <= 1'b0;
      HOST.wr(`SDM_REG_MASK, 32'h0000_03ff);
      core_en_in <= 1'b1;
      rdchk(`SDM_REG_MASK, 32'h0000_0001);
   endtask : t_freeze

   // Measured count and inclusive window limits
   task automatic t_freq();
      osc_run <= 1'b1;
      repeat (60) @(posedge core_clk_in);
      rdchk(`SDM_REG_FREQ, 32'(GATE / 16'h0008));
      flagchk(`SDM_REG_FLAGS, `SDM_F_OSC, 1'b0);
      HOST.wr(`SDM_REG_LO, 32'h0000_0003);
      repeat (40) @(posedge core_clk_in);
      flagchk(`SDM_REG_FLAGS, `SDM_F_OSC, 1'b1);
      HOST.wr(`SDM_REG_LO, 32'h0000_0002);
      repeat (40) @(posedge core_clk_in);
      flagchk(`SDM_REG_FLAGS, `SDM_F_OSC, 1'b0);
      HOST.wr(`SDM_REG_HI, 32'h0000_0001);
      repeat (40) @(posedge core_clk_in);
      flagchk(`SDM_REG_FLAGS, `SDM_F_OSC, 1'b1);
      HOST.wr(`SDM_REG_HI, 32'h0000_0002);
      repeat (40) @(posedge core_clk_in);
      flagchk(`SDM_REG_FLAGS, `SDM_F_OSC, 1'b0);
   endtask : t_freq

   // Injected single error corrected and cleared; double error latched
   task automatic t_ecc();
      HOST.wr(`SDM_REG_INJ, 32'h0200_0001);
      rdchk(`SDM_REG_HI, 32'h0000_0002);
      flagchk(`SDM_REG_FLAGS, `SDM_F_ESGL, 1'b1);
      HOST.wr(`SDM_REG_HI, 32'h0000_0002);
      flagchk(`SDM_REG_FLAGS, `SDM_F_ESGL, 1'b0);
      HOST.wr(`SDM_REG_INJ, 32'h0200_0003);
      repeat (2) @(posedge core_clk_in);
      flagchk(`SDM_REG_FLAGS, `SDM_F_EDBL, 1'b1);
      HOST.wr(`SDM_REG_HI, 32'h0000_0002);
      flagchk(`SDM_REG_FLAGS, `SDM_F_EDBL, 1'b1);
   endtask : t_ecc

   ////////////////////////////////////////////////////////////////////////////
   // Hang guard
   initial
   begin
      repeat (60000) @(posedge core_clk_in);
      mismatches++;
      $display("mismatch at %0t: run took too long", $time);
      report_and_stop();
   end

   // Main sequence; coil short held high across the startup sample
   initial
   begin
      reset_in   = 1'b1;
      core_en_in = 1'b1;
      pins       = 6'h08;
      tx_osc     = 1'b0;
      osc_run    = 1'b0;
      osc_cnt    = 2'h0;
      mismatches = 0;
      n_tests    = 0;
      repeat (16) @(posedge core_clk_in);
      reset_in <= 1'b0;
      t_reset();
      t_temp();
      t_mech();
      t_irq();
      t_wdog();
      t_freeze();
      t_freq();
      t_ecc();
      report_and_stop();
   end
endmodule : sensor_diagnostic_monitor_tb

/* src/sdm_defines.svh */
// Constants of the sensor diagnostic monitor: widths, offsets, bits, resets.
// Assumes it is included once through sdm_pkg or directly by bare name.
`ifndef SDM_DEFINES_SVH
`define SDM_DEFINES_SVH
// Widths
`define SDM_DW      16
`define SDM_CW      22
`define SDM_SYN_W   5
`define SDM_NF      10
`define SDM_NP      6
`define SDM_SETTLE_W 8
// Register offsets
`define SDM_REG_FLAGS  8'h00
`define SDM_REG_STATUS 8'h04
`define SDM_REG_MASK   8'h08
`define SDM_REG_WDOG   8'h0c
`define SDM_REG_LO     8'h10
`define SDM_REG_HI     8'h14
`define SDM_REG_FREQ   8'h18
`define SDM_REG_INJ    8'h1c
// Flag bit positions
`define SDM_F_WDOG  0
`define SDM_F_MECH  1
`define SDM_F_OMEAN 2
`define SDM_F_OOVL  3
`define SDM_F_SHORT 4
`define SDM_F_COIL2 5
`define SDM_F_COIL1 6
`define SDM_F_ESGL  7
`define SDM_F_EDBL  8
`define SDM_F_OSC   9
// Synchroniser positions of the fault pins
`define SDM_P_MECH  0
`define SDM_P_OMEAN 1
`define SDM_P_OOVL  2
`define SDM_P_SHORT 3
`define SDM_P_COIL1 4
`define SDM_P_COIL2 5
// Config slots and inject field
`define SDM_C_PER   0
`define SDM_C_LO    1
`define SDM_C_HI    2
`define SDM_INJ_SEL 25:24
// Reset values
`define SDM_MASK_RST 10'h000
`define SDM_HI_RST   16'hffff
// Timing counts
`define SDM_STARTUP_CYC 16
`define SDM_GATE_CYC    1024
`endif

/* src/sdm_freq_if.sv */
// Link between the monitor and its oscillator frequency meter.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface sdm_freq_if;
   import sdm_pkg::*;
   sdm_word_t value;
   sdm_word_t lo;
   sdm_word_t hi;
   logic      valid;
   logic      alarm;
   modport meter (input lo, input hi, output value, output valid, output alarm);
   modport mon   (output lo, output hi, input value, input valid, input alarm);
endinterface : sdm_freq_if

/* src/sdm_freq_meter.sv */
// Transmitter oscillator frequency meter with window limit alarm.
// Assumes the oscillator is slower than half of core_clk_in.
`timescale 1ns/1ps
module sdm_freq_meter
   import sdm_pkg::*;
#(
   parameter sdm_word_t GATE_CYC = `SDM_GATE_CYC
)(
   input  wire logic core_clk_in,
   input  wire logic reset_in,
   input  wire logic core_en_in,
   input  wire logic tx_osc_in,
   sdm_freq_if.meter fq
);
   sdm_mtr_t q;
   sdm_mtr_t n;
   sdm_word_t cnt;

   ////////////////////////////////////////////////////////////////////
   // Count rising oscillator edges over a fixed gate window
   assign cnt = q.edges + sdm_word_t'(q.s2 & ~q.s3);
   always_comb
   begin
      n = q;
      n.s1 = tx_osc_in;
      n.s2 = q.s1;
      n.s3 = q.s2;
      n.valid = 1'b0;
      n.edges = cnt;
      n.gate = q.gate + 1'b1;
      if (q.gate == GATE_CYC - 1'b1)
      begin
         n.gate = '0;
         n.edges = '0;
         n.value = cnt;
         n.valid = 1'b1;
         n.alarm = (cnt < fq.lo) || (cnt > fq.hi);
      end
   end

   always_ff @(posedge core_clk_in)
   begin
      if (reset_in)
         q <= '0;
      else if (core_en_in)
         q <= n;
   end

   assign fq.value = q.value;
   assign fq.valid = q.valid;
   assign fq.alarm = q.alarm;

   ////////////////////////////////////////////////////////////////////
   // Checks
   property p_freq_alarm;
      @(posedge core_clk_in) disable iff (reset_in)
      q.valid |-> (q.alarm == ((q.value < $past(fq.lo)) || (q.value > $past(fq.hi))));
   endproperty
   a_freq_alarm: assert property (p_freq_alarm) else $error("frequency alarm wrong");
   property p_freq_gate;
      @(posedge core_clk_in) disable iff (reset_in)
      q.valid |-> (q.gate == '0);
   endproperty
   a_freq_gate: assert property (p_freq_gate) else $error("value off the gate edge");
endmodule : sdm_freq_meter

/* src/sdm_monitor.sv */
// Diagnostic monitor: fault flags, watchdog, protected config, interrupt.
// Assumes fault pins are asynchronous levels and a one-clock register port.
//
// Functional notes
// - Running watchdog raises its event on each expiry and restarts itself.
// - Mechanical damage is watched always and latched until reset.
// - Output mean fault flag follows the mean fault pin.
// - Output overload flag follows the overload pin.
// - Coil short is sampled once after reset and held until reset.
// - Second coil failure flag follows its fault pin.
// - First coil failure flag follows its fault pin.
// - Config storage carries a check code; single corrected, double flagged.
// - Oscillator frequency is measured and readable as a count.
// - Count outside host limits raises the frequency alarm flag.
// - Static flags stay set once raised until reset.
// - Temporary flags clear when their cause has gone.
//
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
module sdm_monitor
   import sdm_pkg::*;
#(
   parameter sdm_word_t GATE_CYC = `SDM_GATE_CYC
)(
   input  wire logic        core_clk_in,
   input  wire logic        reset_in,
   input  wire logic        core_en_in,
   input  wire logic [7:0]  reg_addr_in,
   input  wire logic [31:0] reg_wdata_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   output logic      [31:0] reg_rdata_out,
   input  wire logic        mech_damage_in,
   input  wire logic        out_mean_fault_in,
   input  wire logic        out_overload_in,
   input  wire logic        coil_short_in,
   input  wire logic        receive_coil_first_fault_in,
   input  wire logic        receive_coil_second_fault_in,
   input  wire logic        tx_osc_in,
   output logic             select_or_interrupt_pin_n_out
);

   ////////////////////////////////////////////////////////////////////
   // Check code helpers: extended Hamming over a 16-bit word

   // Spread data over non power-of-two positions, then fix parities
   function automatic sdm_cw_t sdm_enc(input sdm_word_t d);
      sdm_cw_t                cw;
      logic [`SDM_SYN_W-1:0]  syn;
      int                     k;
      cw = '0;
      syn = '0;
      k = 0;
      for (int i = 1; i < `SDM_CW; i++)
         if ((i & (i - 1)) != 0)
         begin
            cw[i] = d[k];
            k++;
         end
      for (int i = 1; i < `SDM_CW; i++)
         if (cw[i])
            syn ^= `SDM_SYN_W'(i);
      for (int j = 0; j < `SDM_SYN_W; j++)
         cw[1 << j] = syn[j];
      cw[0] = ^cw[`SDM_CW-1:1];
      return cw;
   endfunction : sdm_enc

   // Returns {double, single, corrected data}
   function automatic logic [`SDM_DW+1:0] sdm_dec(input sdm_cw_t cw);
      logic [`SDM_SYN_W-1:0]  syn;
      logic                   par;
      logic                   dbl;
      sdm_cw_t                fx;
      sdm_word_t              d;
      int                     k;
      syn = '0;
      par = ^cw;
      fx = cw;
      d = '0;
      k = 0;
      for (int i = 1; i < `SDM_CW; i++)
         if (cw[i])
            syn ^= `SDM_SYN_W'(i);
      // A syndrome past the word means more than one bit went bad
      dbl = ((syn != '0) && !par) || (par && (syn >= `SDM_SYN_W'(`SDM_CW)));
      if (par && !dbl)
         fx[syn] = ~fx[syn];
      for (int i = 1; i < `SDM_CW; i++)
         if ((i & (i - 1)) != 0)
         begin
            d[k] = fx[i];
            k++;
         end
      return {dbl, par & ~dbl, d};
   endfunction : sdm_dec

   localparam sdm_cw_t            HI_RST_CW = sdm_enc(`SDM_HI_RST);
   localparam logic [`SDM_NF-1:0] WDOG_M    = `SDM_NF'(1) << `SDM_F_WDOG;

   ////////////////////////////////////////////////////////////////////
   // State and decoded views

   sdm_mon_t             q;
   sdm_mon_t             n;
   logic [`SDM_DW+1:0]   dec_per;
   logic [`SDM_DW+1:0]   dec_lo;
   logic [`SDM_DW+1:0]   dec_hi;
   sdm_word_t            per;
   logic                 ecc_sgl;
   logic                 ecc_dbl;
   logic                 wfire;
   logic [`SDM_NF-1:0]   flags;
   logic [`SDM_NF-1:0]   lvl;
   logic [`SDM_NF-1:0]   ev;
   logic [`SDM_NF-1:0]   clr;
   sdm_freq_if           fq ();

   assign dec_per = sdm_dec(q.cfg[`SDM_C_PER]);
   assign dec_lo  = sdm_dec(q.cfg[`SDM_C_LO]);
   assign dec_hi  = sdm_dec(q.cfg[`SDM_C_HI]);
   assign per     = dec_per[`SDM_DW-1:0];
   assign fq.lo   = dec_lo[`SDM_DW-1:0];
   assign fq.hi   = dec_hi[`SDM_DW-1:0];
   assign ecc_sgl = dec_per[`SDM_DW] | dec_lo[`SDM_DW] | dec_hi[`SDM_DW];
   assign ecc_dbl = dec_per[`SDM_DW+1] | dec_lo[`SDM_DW+1] | dec_hi[`SDM_DW+1];

   ////////////////////////////////////////////////////////////////////
   // Frequency meter

   sdm_freq_meter #(
      .GATE_CYC    (GATE_CYC)
   ) u_meter (
      .core_clk_in (core_clk_in),
      .reset_in    (reset_in),
      .core_en_in  (core_en_in),
      .tx_osc_in   (tx_osc_in),
      .fq          (fq.meter)
   );

   ////////////////////////////////////////////////////////////////////
   // Flag vector: static bits from latches, temporary bits live

   // expiry when count reaches one less than the period
   assign wfire = (per != '0) && (q.wcnt >= per - 1'b1);

   always_comb
   begin
      flags = '0;
      flags[`SDM_F_WDOG]  = q.wdog;
      flags[`SDM_F_MECH]  = q.mech;
      flags[`SDM_F_SHORT] = q.short_res;
      flags[`SDM_F_EDBL]  = q.ecc_dbl;
      flags[`SDM_F_OMEAN] = q.s2[`SDM_P_OMEAN];
      flags[`SDM_F_OOVL]  = q.s2[`SDM_P_OOVL];
      flags[`SDM_F_COIL2] = q.s2[`SDM_P_COIL2];
      flags[`SDM_F_COIL1] = q.s2[`SDM_P_COIL1];
      flags[`SDM_F_ESGL]  = ecc_sgl;
      flags[`SDM_F_OSC]   = fq.alarm;
   end

   // Watchdog latch never ends, so its cyclic events reach the pin by status only
   assign lvl = flags & ~WDOG_M;
   assign ev  = (flags & ~q.prev) | (wfire ? WDOG_M : '0);
   assign clr = (reg_wr_in && (reg_addr_in == `SDM_REG_STATUS)) ? reg_wdata_in[`SDM_NF-1:0] : '0;

   ////////////////////////////////////////////////////////////////////
   // Next state

   always_comb
   begin
      n = q;
      // Two-flop synchronisers on the fault pins
      n.s1[`SDM_P_MECH]  = mech_damage_in;
      n.s1[`SDM_P_OMEAN] = out_mean_fault_in;
      n.s1[`SDM_P_OOVL]  = out_overload_in;
      n.s1[`SDM_P_SHORT] = coil_short_in;
      n.s1[`SDM_P_COIL1] = receive_coil_first_fault_in;
      n.s1[`SDM_P_COIL2] = receive_coil_second_fault_in;
      n.s2 = q.s1;
      n.mech = q.mech | q.s2[`SDM_P_MECH];
      n.ecc_dbl = q.ecc_dbl | ecc_dbl;
      case (q.phase)
         SDM_PH_SETTLE:
         begin
            n.settle = q.settle + 1'b1;
            if (q.settle == `SDM_SETTLE_W'(`SDM_STARTUP_CYC - 1))
            begin
               n.short_res = q.s2[`SDM_P_SHORT];
               n.phase = SDM_PH_RUN;
            end
         end
         SDM_PH_RUN:
            n.settle = q.settle;
         default:
            n.phase = SDM_PH_SETTLE;
      endcase
      if (wfire || (per == '0))
         n.wcnt = '0;
      else
         n.wcnt = q.wcnt + 1'b1;
      // first expiry latches the static flag
      n.wdog = q.wdog | wfire;
      // Status: a set in the clearing cycle wins
      n.status = (q.status & ~clr) | ev;
      n.prev = flags;
      // Register writes
      if (reg_wr_in)
      begin
         if (reg_addr_in == `SDM_REG_MASK)
            n.mask = reg_wdata_in[`SDM_NF-1:0];
         else if (reg_addr_in == `SDM_REG_WDOG)
         begin
            n.cfg[`SDM_C_PER] = sdm_enc(reg_wdata_in[`SDM_DW-1:0]);
            n.wcnt = '0;
         end
         else if (reg_addr_in == `SDM_REG_LO)
            n.cfg[`SDM_C_LO] = sdm_enc(reg_wdata_in[`SDM_DW-1:0]);
         else if (reg_addr_in == `SDM_REG_HI)
            n.cfg[`SDM_C_HI] = sdm_enc(reg_wdata_in[`SDM_DW-1:0]);
         else if ((reg_addr_in == `SDM_REG_INJ) && (reg_wdata_in[`SDM_INJ_SEL] != 2'h3))
            // Test hook: flips stored bits so the check path can be exercised
            n.cfg[reg_wdata_in[`SDM_INJ_SEL]] = q.cfg[reg_wdata_in[`SDM_INJ_SEL]] ^ reg_wdata_in[`SDM_CW-1:0];
      end
      // Register reads, data valid the cycle after the strobe only
      n.rdata = '0;
      if (reg_rd_in)
      begin
         if (reg_addr_in == `SDM_REG_FLAGS)
            n.rdata = 32'(flags);
         else if (reg_addr_in == `SDM_REG_STATUS)
            n.rdata = 32'(q.status);
         else if (reg_addr_in == `SDM_REG_MASK)
            n.rdata = 32'(q.mask);
         else if (reg_addr_in == `SDM_REG_WDOG)
            n.rdata = 32'(per);
         else if (reg_addr_in == `SDM_REG_LO)
            n.rdata = 32'(fq.lo);
         else if (reg_addr_in == `SDM_REG_HI)
            n.rdata = 32'(fq.hi);
         else if (reg_addr_in == `SDM_REG_FREQ)
            n.rdata = 32'(fq.value);
         else
            n.rdata = '0;
      end
      // enabled flags or events drive the pin
      n.irq_n = ~|(q.mask & (q.status | lvl));
   end

   ////////////////////////////////////////////////////////////////////
   // State register; low enable freezes everything

   always_ff @(posedge core_clk_in)
   begin
      if (reset_in)
      begin
         q <= '0;
         q.phase <= SDM_PH_SETTLE;
         q.cfg[`SDM_C_HI] <= HI_RST_CW;
         q.mask <= `SDM_MASK_RST;
         q.irq_n <= 1'b1;
      end
      else if (core_en_in)
         q <= n;
   end

   assign reg_rdata_out = q.rdata;
   assign select_or_interrupt_pin_n_out = q.irq_n;

   ////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (reset_in);

   sequence s_fire;
      core_en_in && wfire;
   endsequence
   sequence s_restart;
      q.status[`SDM_F_WDOG] && (q.wcnt == '0);
   endsequence
   property p_wdog_cycle;
      s_fire |=> s_restart;
   endproperty
   a_wdog_cycle: assert property (p_wdog_cycle) else $error("watchdog did not fire and restart");

   property p_wdog_stop;
      (core_en_in && (per == '0)) |=> (q.wcnt == '0);
   endproperty
   a_wdog_stop: assert property (p_wdog_stop) else $error("watchdog ran with zero period");

   property p_mech_hold;
      q.mech |=> q.mech;
   endproperty
   a_mech_hold: assert property (p_mech_hold) else $error("damage flag dropped");

   property p_omean;
      (!out_mean_fault_in && core_en_in) [*3] |-> !flags[`SDM_F_OMEAN];
   endproperty
   a_omean: assert property (p_omean) else $error("mean flag stuck after cause left");

   property p_oovl;
      (out_overload_in && core_en_in) [*3] |-> flags[`SDM_F_OOVL];
   endproperty
   a_oovl: assert property (p_oovl) else $error("overload flag missing");

   property p_short_hold;
      (q.phase == SDM_PH_RUN) |=> $stable(q.short_res) && (q.phase == SDM_PH_RUN);
   endproperty
   a_short_hold: assert property (p_short_hold) else $error("coil short result changed");

   property p_coil2;
      (receive_coil_second_fault_in && core_en_in) [*3] |-> flags[`SDM_F_COIL2];
   endproperty
   a_coil2: assert property (p_coil2) else $error("second coil flag missing");

   property p_coil1;
      (receive_coil_first_fault_in && core_en_in) [*3] |-> flags[`SDM_F_COIL1];
   endproperty
   a_coil1: assert property (p_coil1) else $error("first coil flag missing");

   property p_ecc_fix;
      (core_en_in && reg_wr_in && (reg_addr_in == `SDM_REG_INJ) && $onehot(reg_wdata_in[`SDM_CW-1:0])
       && (reg_wdata_in[`SDM_INJ_SEL] == 2'h2) && (dec_hi[`SDM_DW+1:`SDM_DW] == 2'h0))
      |=> flags[`SDM_F_ESGL] && (fq.hi == $past(fq.hi));
   endproperty
   a_ecc_fix: assert property (p_ecc_fix) else $error("single error not corrected");

   property p_ecc_hold;
      q.ecc_dbl |=> q.ecc_dbl;
   endproperty
   a_ecc_hold: assert property (p_ecc_hold) else $error("double error flag dropped");

   property p_freq_hold;
      $changed(fq.value) |-> fq.valid;
   endproperty
   a_freq_hold: assert property (p_freq_hold) else $error("frequency value changed off the gate");

   property p_irq;
      (core_en_in && |(q.mask & lvl)) |=> !select_or_interrupt_pin_n_out;
   endproperty
   a_irq: assert property (p_irq) else $error("enabled flag did not pull pin");

endmodule : sdm_monitor

/* src/sdm_pkg.sv */
// Types of the sensor diagnostic monitor.
// Assumes sdm_defines.svh is on the include path.
`include "sdm_defines.svh"
package sdm_pkg;
   typedef logic [`SDM_DW-1:0] sdm_word_t;
   typedef logic [`SDM_CW-1:0] sdm_cw_t;
   typedef enum logic {SDM_PH_SETTLE, SDM_PH_RUN} sdm_phase_t;
   typedef struct packed {
      logic [`SDM_NP-1:0]       s1;
      logic [`SDM_NP-1:0]       s2;
      sdm_phase_t               phase;
      logic [`SDM_SETTLE_W-1:0] settle;
      logic                     mech;
      logic                     short_res;
      logic                     wdog;
      logic                     ecc_dbl;
      logic [2:0][`SDM_CW-1:0]  cfg;
      sdm_word_t                wcnt;
      logic [`SDM_NF-1:0]       prev;
      logic [`SDM_NF-1:0]       status;
      logic [`SDM_NF-1:0]       mask;
      logic [31:0]              rdata;
      logic                     irq_n;
   } sdm_mon_t;
   typedef struct packed {
      logic      s1;
      logic      s2;
      logic      s3;
      sdm_word_t gate;
      sdm_word_t edges;
      sdm_word_t value;
      logic      valid;
      logic      alarm;
   } sdm_mtr_t;
endpackage : sdm_pkg
